// *** verilog/asr_alert_regs.sv ***
// alert summary and cell overvoltage registers behind an AXI4-Lite slave
// assumes acquisition and calibration inputs come from logic on aclk
// Notes on behaviour
// - bit 15 is OR of cell ADC overvoltage
// - bit 14 is OR of comparator cell overvoltage
// - bit 13 is OR of cell ADC undervoltage
// - bit 12 is OR of comparator cell undervoltage
// - bit 11 is OR of aux ADC cold
// - bit 10 is OR of aux comparator cold
// - bit 9 is OR of aux ADC hot
// - bit 8 is OR of aux comparator hot
// - voltage summaries hold until next acquisition
// - bit 4 flags ADC offset calibration fault
// - bit 3 flags shift amp offset fault
// - bit 2 flags ratiometric offset fault
// - bit 1 flags pyramid gain fault
// - bit 0 flags ramp gain fault
// - fault clears on good run or in-range write; out-of-range write sets it
// - summary read-only, resets zero, bits 7:5 zero
// - cell bit set above its polarity threshold
// - cell alert only when enabled
// - cell bit re-evaluated each acquisition
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module asr_alert_regs
  import asr_pkg::*;
(
  // clock and reset
  input  logic                  aclk,
  input  logic                  aresetn,
  // axi4-lite write
  input  logic [AW-1:0]         awaddr,
  input  logic                  awvalid,
  output logic                  awready,
  input  logic [31:0]           wdata,
  input  logic [3:0]            wstrb,
  input  logic                  wvalid,
  output logic                  wready,
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  logic                  bready,
  // axi4-lite read
  input  logic [AW-1:0]         araddr,
  input  logic                  arvalid,
  output logic                  arready,
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  logic                  rready,
  // acquisition results
  input  logic                  acq_done,
  input  logic [N_CELLS*VW-1:0] cell_voltage,
  input  logic [N_CELLS-1:0]    cmp_cell_ov_alert_bits,
  input  logic [N_CELLS-1:0]    cell_uv_alert_bits,
  input  logic [N_CELLS-1:0]    cmp_cell_uv_alert_bits,
  input  logic [N_AUX-1:0]      aux_cold_alert_bits,
  input  logic [N_AUX-1:0]      cmp_aux_cold_alert_bits,
  input  logic [N_AUX-1:0]      aux_hot_alert_bits,
  input  logic [N_AUX-1:0]      cmp_aux_hot_alert_bits,
  // calibration results
  input  logic                  cal_done,
  input  logic [CAL_N-1:0]      cal_run,
  input  logic [CAL_N-1:0]      cal_fault,
  // status towards the device
  output logic [15:0]           alert_summary_status,
  output logic [15:0]           cell_overvoltage_alerts
);

  // write channel state
  logic          aw_have_q, aw_have_d;
  logic          w_have_q, w_have_d;
  logic [9:0]    aw_idx_q, aw_idx_d;
  logic [31:0]   wdata_q, wdata_d;
  logic [3:0]    wstrb_q, wstrb_d;
  logic          bvalid_q, bvalid_d;
  logic [1:0]    bresp_q, bresp_d;
  logic          do_write;
  logic          wr_hit;

  // read channel state
  logic          rvalid_q, rvalid_d;
  logic [31:0]   rdata_q, rdata_d;
  logic [1:0]    rresp_q, rresp_d;
  logic [9:0]    ar_idx;

  // configuration
  logic [VW-1:0]      uni_thr_q, uni_thr_d;
  logic [VW-1:0]      bip_thr_q, bip_thr_d;
  logic [N_CELLS-1:0] ov_en_q, ov_en_d;
  logic [N_CELLS-1:0] polarity_q, polarity_d;
  logic [VW-1:0]      cal_val_q [CAL_N];
  logic [VW-1:0]      cal_val_d [CAL_N];
  logic [VW-1:0]      wr_merged;
  logic               cal_in_bounds;
  logic [CAL_N-1:0]   cal_wr_sel;

  // alert state
  logic [7:0]         volt_sum_q, volt_sum_d;
  logic [N_CELLS-1:0] cell_ov_q, cell_ov_d;
  logic [CAL_N-1:0]   cal_flt_q, cal_flt_d;
  logic [CAL_N-1:0]   cal_set, cal_clr;
  logic [N_CELLS-1:0] ov_hit;

  asr_cell_ov_cmp u_ov_cmp (
    .cell_voltage (cell_voltage),
    .uni_thr      (uni_thr_q),
    .bip_thr      (bip_thr_q),
    .ov_en        (ov_en_q),
    .polarity     (polarity_q),
    .ov_hit       (ov_hit)
  );

  // bus handshakes
  assign awready  = !aw_have_q && !bvalid_q;
  assign wready   = !w_have_q && !bvalid_q;
  assign arready  = !rvalid_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign bvalid   = bvalid_q;
  assign bresp    = bresp_q;
  assign rvalid   = rvalid_q;
  assign rdata    = rdata_q;
  assign rresp    = rresp_q;
  assign ar_idx   = araddr[AW-1:2];

  // write strobes apply per byte lane to the low half-word
  assign wr_merged = {wstrb_q[1] ? wdata_q[15:8] : 8'h00, wstrb_q[0] ? wdata_q[7:0] : 8'h00};
  assign cal_in_bounds = ($signed(wr_merged) >= CAL_LIMIT_LO) && ($signed(wr_merged) <= CAL_LIMIT_HI);

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    aw_idx_d  = aw_idx_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    wr_hit    = 1'b0;
    if (awvalid && awready) begin
      aw_have_d = 1'b1;
      aw_idx_d  = awaddr[AW-1:2];
    end
    if (wvalid && wready) begin
      w_have_d = 1'b1;
      wdata_d  = wdata;
      wstrb_d  = wstrb;
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      wr_hit    = (aw_idx_q == IDX_ALERT_SUMMARY) || (aw_idx_q == IDX_CELL_OV) || (aw_idx_q == IDX_UNI_THR) ||
                  (aw_idx_q == IDX_BIP_THR) || (aw_idx_q == IDX_OV_EN) || (aw_idx_q == IDX_POLARITY) ||
                  ((aw_idx_q >= IDX_CAL_BASE) && (aw_idx_q < IDX_CAL_BASE + 10'(CAL_N)));
      bresp_d   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_idx_q  <= 10'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      aw_idx_q  <= aw_idx_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // configuration registers; summary and cell alert offsets ignore writes
  always_comb begin
    uni_thr_d  = uni_thr_q;
    bip_thr_d  = bip_thr_q;
    ov_en_d    = ov_en_q;
    polarity_d = polarity_q;
    cal_wr_sel = '0;
    for (int i = 0; i < CAL_N; i++) begin
      cal_val_d[i] = cal_val_q[i];
    end
    if (do_write) begin
      case (aw_idx_q)
        IDX_UNI_THR:  uni_thr_d  = wr_merged;
        IDX_BIP_THR:  bip_thr_d  = wr_merged;
        IDX_OV_EN:    ov_en_d    = wr_merged[N_CELLS-1:0];
        IDX_POLARITY: polarity_d = wr_merged[N_CELLS-1:0];
        default: begin
          for (int i = 0; i < CAL_N; i++) begin
            if (aw_idx_q == IDX_CAL_BASE + 10'(i)) begin
              cal_wr_sel[i] = 1'b1;
              cal_val_d[i]  = wr_merged;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uni_thr_q  <= RST_UNI_THR;
      bip_thr_q  <= RST_BIP_THR;
      ov_en_q    <= RST_OV_EN;
      polarity_q <= RST_POLARITY;
      for (int i = 0; i < CAL_N; i++) begin
        cal_val_q[i] <= RST_CAL_VAL;
      end
    end else begin
      uni_thr_q  <= uni_thr_d;
      bip_thr_q  <= bip_thr_d;
      ov_en_q    <= ov_en_d;
      polarity_q <= polarity_d;
      for (int i = 0; i < CAL_N; i++) begin
        cal_val_q[i] <= cal_val_d[i];
      end
    end
  end

  // alert bits; everything tied to the acquisition moves on one edge
  always_comb begin
    volt_sum_d = volt_sum_q;
    cell_ov_d  = cell_ov_q;
    if (acq_done) begin
      cell_ov_d = ov_hit;
      volt_sum_d[SUM_ADC_CELL_OV-SUM_VOLT_LSB] = |ov_hit;
      volt_sum_d[SUM_CMP_CELL_OV-SUM_VOLT_LSB] = |cmp_cell_ov_alert_bits;
      volt_sum_d[SUM_ADC_CELL_UV-SUM_VOLT_LSB] = |cell_uv_alert_bits;
      volt_sum_d[SUM_CMP_CELL_UV-SUM_VOLT_LSB] = |cmp_cell_uv_alert_bits;
      volt_sum_d[SUM_ADC_AUX_CLD-SUM_VOLT_LSB] = |aux_cold_alert_bits;
      volt_sum_d[SUM_CMP_AUX_CLD-SUM_VOLT_LSB] = |cmp_aux_cold_alert_bits;
      volt_sum_d[SUM_ADC_AUX_HOT-SUM_VOLT_LSB] = |aux_hot_alert_bits;
      volt_sum_d[SUM_CMP_AUX_HOT-SUM_VOLT_LSB] = |cmp_aux_hot_alert_bits;
    end
    // a failing run beats a clearing write in the same cycle
    cal_set   = (cal_done ? (cal_run & cal_fault) : '0) | (cal_in_bounds ? '0 : cal_wr_sel);
    cal_clr   = (cal_done ? (cal_run & ~cal_fault) : '0) | (cal_in_bounds ? cal_wr_sel : '0);
    cal_flt_d = cal_set | (cal_flt_q & ~cal_clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      volt_sum_q <= RST_VOLT_SUM;
      cell_ov_q  <= RST_CELL_OV;
      cal_flt_q  <= RST_CAL_FLT;
    end else begin
      volt_sum_q <= volt_sum_d;
      cell_ov_q  <= cell_ov_d;
      cal_flt_q  <= cal_flt_d;
    end
  end

  assign alert_summary_status    = {volt_sum_q, 3'h0, cal_flt_q};
  assign cell_overvoltage_alerts = {2'h0, cell_ov_q};

  // read data is registered on the address edge
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (ar_idx)
        IDX_ALERT_SUMMARY: rdata_d = {16'h0000, alert_summary_status};
        IDX_CELL_OV:       rdata_d = {16'h0000, cell_overvoltage_alerts};
        IDX_UNI_THR:       rdata_d = {16'h0000, uni_thr_q};
        IDX_BIP_THR:       rdata_d = {16'h0000, bip_thr_q};
        IDX_OV_EN:         rdata_d = {18'h00000, ov_en_q};
        IDX_POLARITY:      rdata_d = {18'h00000, polarity_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
          for (int i = 0; i < CAL_N; i++) begin
            if (ar_idx == IDX_CAL_BASE + 10'(i)) begin
              rdata_d = {16'h0000, cal_val_q[i]};
              rresp_d = RESP_OKAY;
            end
          end
        end
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_adc_cell_ov_sum;
    acq_done |=> alert_summary_status[SUM_ADC_CELL_OV] == (|cell_overvoltage_alerts);
  endproperty
  a_adc_cell_ov_sum: assert property (p_adc_cell_ov_sum) else $error("cell ov summary mismatch");

  property p_cmp_cell_ov_sum;
    acq_done |=> alert_summary_status[SUM_CMP_CELL_OV] == $past(|cmp_cell_ov_alert_bits);
  endproperty
  a_cmp_cell_ov_sum: assert property (p_cmp_cell_ov_sum) else $error("cmp ov summary mismatch");

  property p_adc_cell_uv_sum;
    acq_done |=> alert_summary_status[SUM_ADC_CELL_UV] == $past(|cell_uv_alert_bits);
  endproperty
  a_adc_cell_uv_sum: assert property (p_adc_cell_uv_sum) else $error("cell uv summary mismatch");

  property p_aux_hot_sum;
    acq_done |=> alert_summary_status[SUM_CMP_AUX_HOT] == $past(|cmp_aux_hot_alert_bits);
  endproperty
  a_aux_hot_sum: assert property (p_aux_hot_sum) else $error("aux hot summary mismatch");

  property p_hold_between_acq;
    !acq_done |=> $stable(alert_summary_status[15:8]) && $stable(cell_overvoltage_alerts);
  endproperty
  a_hold_between_acq: assert property (p_hold_between_acq) else $error("alert moved without acquisition");

  property p_cal_fault_sets;
    cal_done && cal_run[0] && cal_fault[0] |=> alert_summary_status[0];
  endproperty
  a_cal_fault_sets: assert property (p_cal_fault_sets) else $error("ramp gain fault not set");

  property p_cal_good_write_clears;
    do_write && cal_wr_sel[4] && cal_in_bounds && !(cal_done && cal_run[4] && cal_fault[4])
      |=> !alert_summary_status[4];
  endproperty
  a_cal_good_write_clears: assert property (p_cal_good_write_clears) else $error("cal fault kept");

  property p_unused_zero;
    alert_summary_status[7:5] == 3'h0 && cell_overvoltage_alerts[15:14] == 2'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

  property p_enable_gates;
    acq_done |=> (cell_overvoltage_alerts[N_CELLS-1:0] & ~$past(ov_en_q)) == '0;
  endproperty
  a_enable_gates: assert property (p_enable_gates) else $error("disabled cell raised alert");

  property p_write_answer;
    do_write |=> bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");

  property p_read_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");

  c_acq_with_ov: cover property (acq_done ##1 alert_summary_status[SUM_ADC_CELL_OV]);
  c_cal_fault_then_clear: cover property (alert_summary_status[2] ##[1:50] !alert_summary_status[2]);
  c_read_summary: cover property (rvalid && rready && rdata[15]);
  c_write_response: cover property (bvalid && bready && bresp == RESP_OKAY);

endmodule : asr_alert_regs

// *** verilog/asr_pkg.sv ***
// constants for the alert summary and cell overvoltage register bank
// assumes a 32-bit AXI4-Lite register bus and a 20 MHz aclk
package asr_pkg;

  // geometry
  localparam int N_CELLS = 14;
  localparam int N_AUX   = 6;
  localparam int VW      = 16;
  localparam int AW      = 12;
  localparam int CAL_N   = 5;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_ALERT_SUMMARY = 10'h007;
  localparam logic [9:0] IDX_CELL_OV       = 10'h008;
  localparam logic [9:0] IDX_UNI_THR       = 10'h040;
  localparam logic [9:0] IDX_BIP_THR       = 10'h041;
  localparam logic [9:0] IDX_OV_EN         = 10'h042;
  localparam logic [9:0] IDX_POLARITY      = 10'h043;
  localparam logic [9:0] IDX_CAL_BASE      = 10'h050;

  // summary field positions
  localparam int SUM_ADC_CELL_OV = 15;
  localparam int SUM_CMP_CELL_OV = 14;
  localparam int SUM_ADC_CELL_UV = 13;
  localparam int SUM_CMP_CELL_UV = 12;
  localparam int SUM_ADC_AUX_CLD = 11;
  localparam int SUM_CMP_AUX_CLD = 10;
  localparam int SUM_ADC_AUX_HOT = 9;
  localparam int SUM_CMP_AUX_HOT = 8;
  localparam int SUM_VOLT_LSB    = 8;

  // values after reset
  localparam logic [7:0]         RST_VOLT_SUM = 8'h00;
  localparam logic [CAL_N-1:0]   RST_CAL_FLT  = 5'h00;
  localparam logic [N_CELLS-1:0] RST_CELL_OV  = 14'h0000;
  localparam logic [VW-1:0]      RST_UNI_THR  = 16'hD000;
  localparam logic [VW-1:0]      RST_BIP_THR  = 16'h6000;
  localparam logic [N_CELLS-1:0] RST_OV_EN    = 14'h3FFF;
  localparam logic [N_CELLS-1:0] RST_POLARITY = 14'h0000;
  localparam logic [VW-1:0]      RST_CAL_VAL  = 16'h0000;

  // accepted range of a calibration value, two's complement
  localparam logic signed [VW-1:0] CAL_LIMIT_LO = 16'hFF00;
  localparam logic signed [VW-1:0] CAL_LIMIT_HI = 16'h0100;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : asr_pkg

// *** verilog/asr_cell_ov_cmp.sv ***
// per-cell overvoltage threshold compare, purely combinational
// assumes cell voltages are stable while acq_done is high
`timescale 1ns/1ns
module asr_cell_ov_cmp
  import asr_pkg::*;
(
  // measurements
  input  logic [N_CELLS*VW-1:0] cell_voltage,
  // configuration
  input  logic [VW-1:0]         uni_thr,
  input  logic [VW-1:0]         bip_thr,
  input  logic [N_CELLS-1:0]    ov_en,
  input  logic [N_CELLS-1:0]    polarity,
  // result
  output logic [N_CELLS-1:0]    ov_hit
);

  genvar g;
  generate
    for (g = 0; g < N_CELLS; g++) begin : g_cell
      logic [VW-1:0] v;
      logic          over_uni;
      logic          over_bip;
      assign v        = cell_voltage[g*VW +: VW];
      assign over_uni = v > uni_thr;
      // bipolar cells read as signed codes
      assign over_bip = $signed(v) > $signed(bip_thr);
      // disabled cells never raise the alert
      assign ov_hit[g] = ov_en[g] & (polarity[g] ? over_bip : over_uni);
    end
  endgenerate

endmodule : asr_cell_ov_cmp

// *** tb/tb.sv ***
// self-checking bench for the alert summary and cell overvoltage register bank
// assumes asr_pkg and asr_alert_regs are compiled first; the bench drives every port itself
`timescale 1ns/1ns
module tb;
  import asr_pkg::*;
  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  logic [AW-1:0]         awaddr = '0, araddr = '0;
  logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0]           wdata = '0;
  logic [3:0]            wstrb = 4'h0;
  logic [3:0]            wr_strb = 4'hF;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [1:0]            bresp, rresp;
  logic [31:0]           rdata;
  logic                  acq_done = 1'b0, cal_done = 1'b0;
  logic [N_CELLS*VW-1:0] cell_voltage = '0;
  logic [N_CELLS-1:0]    cmp_cell_ov_alert_bits = '0, cell_uv_alert_bits = '0, cmp_cell_uv_alert_bits = '0;
  logic [N_AUX-1:0]      aux_cold_alert_bits = '0, cmp_aux_cold_alert_bits = '0;
  logic [N_AUX-1:0]      aux_hot_alert_bits = '0, cmp_aux_hot_alert_bits = '0;
  logic [CAL_N-1:0]      cal_run = '0, cal_fault = '0;
  logic [15:0]           alert_summary_status, cell_overvoltage_alerts;
  // reference model state
  logic [VW-1:0]         m_uni, m_bip;
  logic [N_CELLS-1:0]    m_en, m_pol, m_cov;
  logic [7:0]            m_volt;
  logic [CAL_N-1:0]      m_cal;
  int                    mismatches = 0, samples_checked = 0, cycles = 0;

  asr_alert_regs asr_alert_regs_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .acq_done(acq_done), .cell_voltage(cell_voltage),
    .cmp_cell_ov_alert_bits(cmp_cell_ov_alert_bits), .cell_uv_alert_bits(cell_uv_alert_bits),
    .cmp_cell_uv_alert_bits(cmp_cell_uv_alert_bits), .aux_cold_alert_bits(aux_cold_alert_bits),
    .cmp_aux_cold_alert_bits(cmp_aux_cold_alert_bits), .aux_hot_alert_bits(aux_hot_alert_bits),
    .cmp_aux_hot_alert_bits(cmp_aux_hot_alert_bits), .cal_done(cal_done), .cal_run(cal_run),
    .cal_fault(cal_fault), .alert_summary_status(alert_summary_status),
    .cell_overvoltage_alerts(cell_overvoltage_alerts));

  always #25 aclk = ~aclk;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // a hung handshake ends here
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32

  task automatic chk2(input string what, input logic [1:0] exp, input logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk2

  // readies are sampled at the falling edge so the rising-edge decision never races the design
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
    logic aw_hit, w_hit, b_hit;
    logic [1:0] resp;
    b_hit = 1'b0;
    resp = 2'h1;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= wr_strb; wvalid <= 1'b1; bready <= 1'b1;
    while (!b_hit) begin
      @(negedge aclk);
      aw_hit = awvalid && (awready === 1'b1);
      w_hit = wvalid && (wready === 1'b1);
      b_hit = (bvalid === 1'b1);
      if (b_hit) resp = bresp;
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (b_hit) bready <= 1'b0;
    end
    chk2("bresp", exp_resp, resp);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    logic ar_hit, r_hit;
    logic [31:0] data;
    logic [1:0] resp;
    r_hit = 1'b0;
    data = 'x;
    resp = 2'h1;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!r_hit) begin
      @(negedge aclk);
      ar_hit = arvalid && (arready === 1'b1);
      r_hit = (rvalid === 1'b1);
      if (r_hit) begin
        data = rdata;
        resp = rresp;
      end
      @(posedge aclk);
      if (ar_hit) arvalid <= 1'b0;
      if (r_hit) rready <= 1'b0;
    end
    chk32("rdata", exp, data);
    chk2("rresp", exp_resp, resp);
  endtask : rd

  function automatic logic [13:0] sparse(input int w);
    case ($urandom % 3)
      0: return 14'h0000;
      1: return 14'h0001 << ($urandom % w);
      default: return 14'($urandom) & 14'((1 << w) - 1);
    endcase
  endfunction : sparse

  // strictly greater than the threshold chosen by the cell's polarity
  function automatic logic [N_CELLS-1:0] ov_model(input logic [N_CELLS*VW-1:0] vv);
    logic [N_CELLS-1:0] r;
    logic [VW-1:0] v;
    for (int i = 0; i < N_CELLS; i++) begin
      v = vv[i*VW +: VW];
      r[i] = m_en[i] && (m_pol[i] ? ($signed(v) > $signed(m_bip)) : (v > m_uni));
    end
    return r;
  endfunction : ov_model

  task automatic model_reset;
    m_uni = RST_UNI_THR; m_bip = RST_BIP_THR; m_en = RST_OV_EN; m_pol = RST_POLARITY;
    m_cov = RST_CELL_OV; m_volt = RST_VOLT_SUM; m_cal = RST_CAL_FLT;
  endtask : model_reset

  task automatic check_all;
    @(negedge aclk);
    chk32("summary_out", {16'h0, m_volt, 3'b000, m_cal}, {16'h0, alert_summary_status});
    chk32("cell_ov_out", {18'h0, m_cov}, {16'h0, cell_overvoltage_alerts});
    rd(12'h01C, {16'h0, m_volt, 3'b000, m_cal}, RESP_OKAY);
    rd(12'h020, {18'h0, m_cov}, RESP_OKAY);
  endtask : check_all

  task automatic config_rand;
    m_uni = 16'($urandom); m_bip = 16'($urandom); m_en = 14'($urandom); m_pol = 14'($urandom);
    wr(12'h100, {16'h0, m_uni}, RESP_OKAY);
    wr(12'h104, {16'h0, m_bip}, RESP_OKAY);
    wr(12'h108, {18'h0, m_en}, RESP_OKAY);
    wr(12'h10C, {18'h0, m_pol}, RESP_OKAY);
  endtask : config_rand

  // inputs are scrambled once the pulse is gone; the registers must hold
  task automatic acquire;
    logic [N_CELLS*VW-1:0] v;
    logic [13:0] a0, a1, a2, x0, x1, x2, x3;
    for (int i = 0; i < N_CELLS; i++) begin
      case ($urandom % 5)
        0: v[i*VW +: VW] = m_uni;
        1: v[i*VW +: VW] = m_uni + 16'h0001;
        2: v[i*VW +: VW] = m_bip;
        3: v[i*VW +: VW] = m_bip + 16'h0001;
        default: v[i*VW +: VW] = 16'($urandom);
      endcase
    end
    a0 = sparse(14); a1 = sparse(14); a2 = sparse(14);
    x0 = sparse(6); x1 = sparse(6); x2 = sparse(6); x3 = sparse(6);
    @(posedge aclk);
    cell_voltage <= v; acq_done <= 1'b1;
    cmp_cell_ov_alert_bits <= a0; cell_uv_alert_bits <= a1; cmp_cell_uv_alert_bits <= a2;
    aux_cold_alert_bits <= x0[5:0]; cmp_aux_cold_alert_bits <= x1[5:0];
    aux_hot_alert_bits <= x2[5:0]; cmp_aux_hot_alert_bits <= x3[5:0];
    m_cov = ov_model(v);
    m_volt = {|m_cov, |a0, |a1, |a2, |x0, |x1, |x2, |x3};
    @(posedge aclk);
    acq_done <= 1'b0; cell_voltage <= ~v;
    cmp_cell_ov_alert_bits <= ~a0; cell_uv_alert_bits <= ~a1; cmp_cell_uv_alert_bits <= ~a2;
    aux_cold_alert_bits <= ~x0[5:0]; cmp_aux_cold_alert_bits <= ~x1[5:0];
    aux_hot_alert_bits <= ~x2[5:0]; cmp_aux_hot_alert_bits <= ~x3[5:0];
  endtask : acquire

  task automatic cal_event(input logic [CAL_N-1:0] run, input logic [CAL_N-1:0] flt);
    @(posedge aclk);
    cal_done <= 1'b1; cal_run <= run; cal_fault <= flt;
    @(posedge aclk);
    cal_done <= 1'b0; cal_run <= 5'h1F; cal_fault <= ~flt;
    m_cal = (m_cal & ~run) | (run & flt);
  endtask : cal_event

  task automatic cal_write(input int b, input logic [VW-1:0] val);
    wr(12'h140 + 12'(4 * b), {16'h0, val}, RESP_OKAY);
    m_cal[b] = ($signed(val) < $signed(CAL_LIMIT_LO)) || ($signed(val) > $signed(CAL_LIMIT_HI));
  endtask : cal_write

  initial begin
    logic [VW-1:0] cal_vals [4];
    cal_vals = '{16'h0101, 16'h0100, 16'hFEFF, 16'hFF00};
    void'($urandom(32'h25AA411F));
    model_reset();
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_all();
    rd(12'h100, {16'h0, RST_UNI_THR}, RESP_OKAY);
    rd(12'h108, {18'h0, RST_OV_EN}, RESP_OKAY);
    $display("test reset done");
    for (int n = 0; n < 40; n++) begin
      if ($urandom % 4 == 0) config_rand();
      acquire();
      if ($urandom % 3 == 0) cal_event(5'($urandom), 5'($urandom));
      check_all();
    end
    $display("test random acquisitions done");
    for (int b = 0; b < CAL_N; b++) begin
      foreach (cal_vals[k]) begin
        cal_write(b, cal_vals[k]);
        check_all();
      end
      cal_write(b, 16'h8000);
      cal_event(5'h01 << b, 5'h00);
      check_all();
    end
    cal_event(5'h1F, 5'h1F);
    cal_event(5'h0A, 5'h00);
    check_all();
    $display("test calibration faults done");
    wr(12'h01C, 32'h0000FFFF, RESP_OKAY);
    wr(12'h020, 32'h0000FFFF, RESP_OKAY);
    wr(12'hFFC, 32'h0000FFFF, RESP_SLVERR);
    rd(12'hFFC, 32'h0, RESP_SLVERR);
    check_all();
    // a lane with its strobe low writes zero
    wr_strb = 4'h1;
    wr(12'h100, 32'h0000ABCD, RESP_OKAY);
    wr_strb = 4'h2;
    wr(12'h104, 32'h0000ABCD, RESP_OKAY);
    wr_strb = 4'hF;
    rd(12'h100, 32'h000000CD, RESP_OKAY);
    rd(12'h104, 32'h0000AB00, RESP_OKAY);
    $display("test read-only and unmapped done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    model_reset();
    @(posedge aclk);
    check_all();
    rd(12'h104, {16'h0, RST_BIP_THR}, RESP_OKAY);
    $display("test second reset done");
    print_verdict();
  end
endmodule : tb
